// ---- logic/rsvs_regs.svh ----
// Purpose: constants for the reset sequence and vector select block
// Assumes: 50 MHz clock, one cycle of it counts as one sequence cycle
// Notes: counts are in clock cycles
`ifndef RSVS_REGS_SVH
`define RSVS_REGS_SVH
// Oscillator startup delay in cycles
`define RSVS_STARTUP_CYCLES 4096
// Recovery low drive in cycles
`define RSVS_DRIVE_CYCLES 16
// Cycles from release to sample
`define RSVS_SAMPLE_CYCLES 9
// Vector addresses
`define RSVS_VEC_NORMAL 16'hfffe
`define RSVS_VEC_CLOCK 16'hfffc
`define RSVS_VEC_WATCHDOG 16'hfffa
`endif

// ---- logic/rsvs_pkg.sv ----
// Purpose: types for the reset sequence and vector select block
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package rsvs_pkg;
  // ***********************
  // Sequence states
  // ***********************
  typedef enum logic [4:0] {
    RSVS_STARTUP = 5'h01, // Oscillator startup delay
    RSVS_DRIVE = 5'h02, // Recovery low drive
    RSVS_RELEASE = 5'h04, // Pin released, waiting to sample
    RSVS_WAIT_HIGH = 5'h08, // External request, wait for release
    RSVS_RUN = 5'h10 // Normal processing
  } rsvs_state_type;
  // Reset cause seen at the sample point
  typedef enum logic [1:0] {
    RSVS_CAUSE_NORMAL = 2'h0,
    RSVS_CAUSE_WATCHDOG = 2'h1,
    RSVS_CAUSE_CLOCK = 2'h2
  } rsvs_cause_type;
endpackage : rsvs_pkg
`default_nettype wire

// ---- logic/rsvs_sync.sv ----
// Purpose: two-stage synchronizer for the reset pin level
// Assumes: reset value high (pin released)
// Notes: first stage feeds only the second
`default_nettype none
module rsvs_sync (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_level,
  output logic o_level
);
  import rsvs_pkg::*;
  // First stage
  logic stage1;
  logic next_stage1;
  logic next_level;
  // ***********************
  // Next values
  // ***********************
  always_comb begin
    next_stage1 = i_level;
    next_level = stage1;
  end
  // ***********************
  // Registers
  // ***********************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= 1'b1;
      o_level <= 1'b1;
    end else begin
      stage1 <= next_stage1;
      o_level <= next_level;
    end
  end
endmodule : rsvs_sync
`default_nettype wire

// ---- logic/rsvs_sticky.sv ----
// Purpose: sticky flag, set wins over clear
// Assumes: set and clear are one clock pulses or levels
// Notes: used for watchdog and clock failure indications
`default_nettype none
module rsvs_sticky (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  import rsvs_pkg::*;
  logic next_flag;
  // Set has priority so no event is lost
  always_comb begin
    next_flag = o_flag;
    if (i_clear) begin
      next_flag = 1'b0;
    end
    if (i_set) begin
      next_flag = 1'b1;
    end
  end
  // Flag register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end
endmodule : rsvs_sticky
`default_nettype wire

// ---- logic/rsvs_seq.sv ----
// Purpose: reset sequencer with vector selection for a bidirectional reset pin
// Assumes: i_resetn is the power-on reset; other inputs synchronous except i_reset_pin
// Notes: pin is open drain; o_reset_pin_oe_n low means pin driven low
`include "rsvs_regs.svh"
`default_nettype none
module rsvs_seq #(
  parameter int STARTUP_CYCLES = `RSVS_STARTUP_CYCLES, // Startup delay count
  parameter int DRIVE_CYCLES = `RSVS_DRIVE_CYCLES, // Recovery low drive count
  parameter int SAMPLE_CYCLES = `RSVS_SAMPLE_CYCLES // Release to sample count
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_watchdog_enable,
  input wire logic i_watchdog_timeout,
  input wire logic i_clock_monitor_enable,
  input wire logic i_clock_fail,
  input wire logic i_reset_pin,
  output logic o_reset_pin,
  output logic o_reset_pin_oe_n,
  output logic o_in_reset,
  output logic [15:0] o_vector,
  output logic o_vector_valid,
  output rsvs_pkg::rsvs_cause_type o_cause
);
  import rsvs_pkg::*;
  // ***********************
  // Parameter checks
  // ***********************
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_bad_startup
    $error("STARTUP_CYCLES out of range");
  end
  if (DRIVE_CYCLES < 1 || DRIVE_CYCLES > 65535) begin : g_bad_drive
    $error("DRIVE_CYCLES out of range");
  end
  if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 65535) begin : g_bad_sample
    $error("SAMPLE_CYCLES out of range");
  end
  localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);
  localparam logic [15:0] DRIVE_LAST = 16'(DRIVE_CYCLES - 1);
  localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYCLES - 1);
  // ***********************
  // Declarations
  // ***********************
  rsvs_state_type state; // Sequence state
  rsvs_state_type next_state;
  logic [15:0] count; // Cycle counter within a state
  logic [15:0] next_count;
  logic [15:0] vector; // Selected vector
  logic [15:0] next_vector;
  logic vector_valid; // Vector selection done
  logic next_vector_valid;
  rsvs_cause_type cause; // Cause at sample
  rsvs_cause_type next_cause;
  logic pin_sync; // Synchronized pin level
  logic watchdog_event; // Enabled watchdog timeout
  logic clock_event; // Enabled clock failure
  logic watchdog_flag; // Sticky watchdog timeout
  logic clock_flag; // Sticky clock failure
  logic clear_flags; // Clear both sticky flags
  logic sample_now; // Sample point reached
  logic drive_low; // Pin drive request
  // Qualify internal sources by their enables
  assign watchdog_event = i_watchdog_enable & i_watchdog_timeout;
  assign clock_event = i_clock_monitor_enable & i_clock_fail;
  assign sample_now = (state == RSVS_RELEASE) && (count == SAMPLE_LAST);
  // ***********************
  // Submodules
  // ***********************
  // Pin level synchronizer
  rsvs_sync u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_level(i_reset_pin),
    .o_level(pin_sync)
  );
  // Sticky watchdog timeout
  rsvs_sticky u_watchdog_flag (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_set(watchdog_event),
    .i_clear(clear_flags),
    .o_flag(watchdog_flag)
  );
  // Sticky clock failure
  rsvs_sticky u_clock_flag (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_set(clock_event),
    .i_clear(clear_flags),
    .o_flag(clock_flag)
  );
  // ***********************
  // Next state logic
  // ***********************
  always_comb begin
    next_state = state;
    next_count = count + 16'h0001;
    next_vector = vector;
    next_vector_valid = vector_valid;
    next_cause = cause;
    clear_flags = 1'b0;
    unique case (state)
      // Startup delay, pin held low
      RSVS_STARTUP: begin
        if (count == STARTUP_LAST) begin
          next_state = RSVS_DRIVE;
          next_count = 16'h0000;
        end
      end
      // Recovery drive; pin held low for exactly DRIVE_CYCLES cycles here, 16 by default, pin sync adds none
      RSVS_DRIVE: begin
        if (count == DRIVE_LAST) begin
          next_state = RSVS_RELEASE;
          next_count = 16'h0000;
        end
      end
      // Released, sample after the wait
      RSVS_RELEASE: begin
        if (sample_now) begin
          next_count = 16'h0000;
          next_vector_valid = 1'b1;
          if (!pin_sync) begin
            next_state = RSVS_WAIT_HIGH;
            clear_flags = 1'b1;
            next_vector = `RSVS_VEC_NORMAL;
            next_cause = RSVS_CAUSE_NORMAL;
            next_vector_valid = 1'b0;
          end else if (clock_flag) begin
            next_state = RSVS_RUN;
            next_vector = `RSVS_VEC_CLOCK;
            next_cause = RSVS_CAUSE_CLOCK;
            clear_flags = 1'b1;
          end else if (watchdog_flag) begin
            next_state = RSVS_RUN;
            next_vector = `RSVS_VEC_WATCHDOG;
            next_cause = RSVS_CAUSE_WATCHDOG;
            clear_flags = 1'b1;
          end else begin
            next_state = RSVS_RUN;
            next_vector = `RSVS_VEC_NORMAL;
            next_cause = RSVS_CAUSE_NORMAL;
          end
        end
      end
      // External request holds pin, wait for release
      RSVS_WAIT_HIGH: begin
        next_count = 16'h0000;
        if (pin_sync) begin
          next_state = RSVS_RUN;
          next_vector_valid = 1'b1;
        end
      end
      // Running; watch for new reset sources
      RSVS_RUN: begin
        next_count = 16'h0000;
        if (clock_event) begin
          next_state = RSVS_STARTUP;
          next_vector_valid = 1'b0;
        end else if (watchdog_event || !pin_sync) begin
          next_state = RSVS_DRIVE;
          next_vector_valid = 1'b0;
        end
      end
      default: begin
        next_state = RSVS_STARTUP;
        next_count = 16'h0000;
        next_vector_valid = 1'b0;
      end
    endcase
  end
  // ***********************
  // State registers
  // ***********************
  // Asynchronous entry to startup, synchronous exit
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= RSVS_STARTUP;
      count <= 16'h0000;
      vector <= `RSVS_VEC_NORMAL;
      vector_valid <= 1'b0;
      cause <= RSVS_CAUSE_NORMAL;
    end else begin
      state <= next_state;
      count <= next_count;
      vector <= next_vector;
      vector_valid <= next_vector_valid;
      cause <= next_cause;
    end
  end
  // ***********************
  // Outputs
  // ***********************
  // Drive low during startup and recovery, also during async reset
  assign drive_low = !i_resetn || (state == RSVS_STARTUP) || (state == RSVS_DRIVE);
  assign o_reset_pin = 1'b0;
  assign o_reset_pin_oe_n = !drive_low;
  assign o_in_reset = !i_resetn || (state != RSVS_RUN);
  assign o_vector = vector;
  assign o_vector_valid = vector_valid;
  assign o_cause = cause;
endmodule : rsvs_seq
`default_nettype wire

// ---- sim/rsvs_chk.sv ----
// Purpose: port checks for the reset sequencer
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top file
`default_nettype none
module rsvs_chk
  import rsvs_pkg::*;
#(
  parameter int STARTUP_CYCLES = 4096, // Startup delay count
  parameter int DRIVE_CYCLES = 16, // Recovery drive count
  parameter int SAMPLE_CYCLES = 9 // Release to sample count
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_watchdog_enable,
  input wire logic i_watchdog_timeout,
  input wire logic i_clock_monitor_enable,
  input wire logic i_clock_fail,
  input wire logic i_reset_pin,
  input wire logic o_reset_pin,
  input wire logic o_reset_pin_oe_n,
  input wire logic o_in_reset,
  input wire logic [15:0] o_vector,
  input wire logic o_vector_valid,
  input wire rsvs_cause_type o_cause
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Low drive length
  // ****************
  logic [15:0] low_cnt; // Cycles of unbroken low drive
  logic [15:0] next_low_cnt;
  // Count while driven, zero on release
  always_comb next_low_cnt = o_reset_pin_oe_n ? 16'h0 : low_cnt + 16'h1;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) low_cnt <= 16'h0;
    else low_cnt <= next_low_cnt;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_pin_never_high:
    assert property (o_reset_pin == 1'b0) else $error("pin data not low");
  a_async_entry:
    assert property (disable iff (1'b0) !i_resetn |-> !o_reset_pin_oe_n && o_in_reset
      && !o_vector_valid) else $error("reset state missing");
  a_wdog_start:
    assert property (o_vector_valid && i_watchdog_enable && i_watchdog_timeout
      |=> !o_reset_pin_oe_n) else $error("watchdog ignored");
  a_clock_start:
    assert property (o_vector_valid && i_clock_monitor_enable && i_clock_fail
      |=> !o_reset_pin_oe_n && o_in_reset) else $error("clock fail ignored");
  a_pin_start:
    assert property (o_vector_valid && !i_reset_pin |-> ##[1:4] !o_reset_pin_oe_n)
      else $error("external low ignored");
  a_quiet_run:
    assert property (o_vector_valid && i_reset_pin && $past(i_reset_pin)
      && $past(i_reset_pin, 2) && !(i_watchdog_enable && i_watchdog_timeout)
      && !(i_clock_monitor_enable && i_clock_fail) |=> o_vector_valid)
      else $error("spurious reset");
  a_drive_len:
    assert property ($rose(o_reset_pin_oe_n) |-> low_cnt inside {[DRIVE_CYCLES:DRIVE_CYCLES+1],
      [STARTUP_CYCLES+DRIVE_CYCLES-1:STARTUP_CYCLES+DRIVE_CYCLES+1]})
      else $error("low drive length wrong");
  a_sample_delay:
    assert property ($rose(o_vector_valid) |-> $past(o_reset_pin_oe_n, 9))
      else $error("sampled too early");
  a_vector_map:
    assert property (o_vector_valid |-> (o_cause == RSVS_CAUSE_CLOCK && o_vector == 16'hfffc)
      || (o_cause == RSVS_CAUSE_WATCHDOG && o_vector == 16'hfffa)
      || (o_cause == RSVS_CAUSE_NORMAL && o_vector == 16'hfffe)) else $error("bad vector");
  c_wdog: cover property ($rose(o_vector_valid) && o_cause == RSVS_CAUSE_WATCHDOG);
  c_clock: cover property ($rose(o_vector_valid) && o_cause == RSVS_CAUSE_CLOCK);
  c_ext: cover property (o_vector_valid && !i_reset_pin);
endmodule : rsvs_chk
`default_nettype wire

// ---- sim/rsvs_board.sv ----
// Purpose: board reset network with pull-up and external switch
// Assumes: pin rises a few cycles after release
// Notes: pull-up gives high when nobody drives low
`default_nettype none
module rsvs_board #(
  parameter int RISE_CYCLES = 2 // Rise time after release
) (
  input wire logic i_clock,
  input wire logic i_oe_n,
  input wire logic i_data,
  input wire logic i_ext_low,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rise_cnt; // Cycles left before valid high
  logic low_drive; // Block pulls the wire low
  // Wire follows the block's data only while its driver is on
  assign low_drive = !i_oe_n && !i_data;
  // Reload while pulled low, then run out
  always_ff @(posedge i_clock) begin
    if (low_drive || i_ext_low) rise_cnt <= RISE_CYCLES[3:0];
    else if (rise_cnt != 4'h0) rise_cnt <= rise_cnt - 4'h1;
  end
  assign o_pin = !(low_drive || i_ext_low || rise_cnt != 4'h0);
endmodule : rsvs_board
`default_nettype wire

// ---- sim/reset_sequence_vector_select_bench.sv ----
// Purpose: scenario bench for the reset sequencer
// Assumes: startup delay shortened to 8 cycles
// Notes: outputs sampled at falling edges, except the async reset check 1 ns after a rising edge
`default_nettype none
module reset_sequence_vector_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rsvs_pkg::*;
  localparam int STARTUP = 8; // Short startup delay
  logic i_clock, i_resetn, wd_en, wd_to, cm_en, cm_fail, ext_low, pin, oe_n, in_reset, valid;
  logic pin_data; // Open-drain data level from the block
  logic [15:0] vector;
  rsvs_cause_type cause;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  rsvs_seq #(.STARTUP_CYCLES(STARTUP)) rsvs_seq_i (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_watchdog_enable(wd_en), .i_watchdog_timeout(wd_to), .i_clock_monitor_enable(cm_en),
    .i_clock_fail(cm_fail), .i_reset_pin(pin), .o_reset_pin(pin_data), .o_reset_pin_oe_n(oe_n),
    .o_in_reset(in_reset), .o_vector(vector), .o_vector_valid(valid), .o_cause(cause));
  rsvs_board rsvs_board_i (.i_clock(i_clock), .i_oe_n(oe_n), .i_data(pin_data),
    .i_ext_low(ext_low), .o_pin(pin));
  // Clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  // Wait for start, then judge vector and cause
  task automatic finish_seq(input logic [15:0] vec, input logic [1:0] cs);
    @(negedge i_clock);
    for (int k = 0; k < 100 && valid !== 1'b1; k++) @(negedge i_clock);
    check({15'h0, valid}, 16'h1);
    check(vector, vec);
    check({14'h0, cause}, {14'h0, cs});
  endtask : finish_seq
  // Measure low drive, allow one cycle of spread
  task automatic run_seq(input int lo, input logic [15:0] vec, input logic [1:0] cs);
    int n;
    n = 0;
    for (int k = 0; k < 10 && oe_n !== 1'b0; k++) @(negedge i_clock);
    check({15'h0, pin_data}, 16'h0);
    while (oe_n === 1'b0 && n < 9000) begin
      n++;
      @(negedge i_clock);
    end
    check({15'h0, n == lo || n == lo + 1}, 16'h1);
    finish_seq(vec, cs);
  endtask : run_seq
  task automatic pulse(input logic wd, input logic cm);
    @(posedge i_clock);
    wd_to <= wd;
    cm_fail <= cm;
    @(posedge i_clock);
    wd_to <= 1'b0;
    cm_fail <= 1'b0;
  endtask : pulse
  // Watchdog alone, then clock fail alone, then both
  task automatic test_internal;
    @(posedge i_clock);
    wd_en <= 1'b1;
    pulse(1'b1, 1'b0);
    run_seq(16, 16'hfffa, RSVS_CAUSE_WATCHDOG);
    @(posedge i_clock);
    cm_en <= 1'b1;
    pulse(1'b0, 1'b1);
    run_seq(STARTUP + 16, 16'hfffc, RSVS_CAUSE_CLOCK);
    pulse(1'b1, 1'b1);
    run_seq(STARTUP + 16, 16'hfffc, RSVS_CAUSE_CLOCK);
  endtask : test_internal
  // Held external low clears a latched watchdog timeout
  task automatic test_external;
    @(posedge i_clock);
    ext_low <= 1'b1;
    repeat (10) @(posedge i_clock);
    pulse(1'b1, 1'b0);
    repeat (60) @(negedge i_clock);
    check({15'h0, valid}, 16'h0);
    @(posedge i_clock);
    ext_low <= 1'b0;
    finish_seq(16'hfffe, RSVS_CAUSE_NORMAL);
    // Short external pulse; cleared watchdog latch must give normal vector
    @(posedge i_clock);
    ext_low <= 1'b1;
    repeat (2) @(posedge i_clock);
    ext_low <= 1'b0;
    run_seq(16, 16'hfffe, RSVS_CAUSE_NORMAL);
  endtask : test_external
  // Disabled sources, then reset entered with no edge
  task automatic test_disabled_async;
    int n;
    n = 0;
    @(posedge i_clock);
    wd_en <= 1'b0;
    cm_en <= 1'b0;
    pulse(1'b1, 1'b1);
    repeat (20) @(negedge i_clock) n += int'(oe_n !== 1'b1);
    check(n[15:0], 16'h0);
    @(posedge i_clock);
    i_resetn <= 1'b0;
    #1 check({14'h0, oe_n, in_reset}, 16'h1);
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    run_seq(STARTUP + 16, 16'hfffe, RSVS_CAUSE_NORMAL);
  endtask : test_disabled_async
  initial begin
    i_resetn = 1'b0;
    wd_en = 1'b0;
    wd_to = 1'b0;
    cm_en = 1'b0;
    cm_fail = 1'b0;
    ext_low = 1'b0;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    run_seq(STARTUP + 16, 16'hfffe, RSVS_CAUSE_NORMAL);
    test_internal();
    test_external();
    test_disabled_async();
    complete_run();
  end
endmodule : reset_sequence_vector_select_bench
bind rsvs_seq rsvs_chk #(.STARTUP_CYCLES(STARTUP_CYCLES), .DRIVE_CYCLES(DRIVE_CYCLES),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) rsvs_chk_i (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_watchdog_enable(i_watchdog_enable), .i_watchdog_timeout(i_watchdog_timeout),
  .i_clock_monitor_enable(i_clock_monitor_enable), .i_clock_fail(i_clock_fail),
  .i_reset_pin(i_reset_pin), .o_reset_pin(o_reset_pin), .o_reset_pin_oe_n(o_reset_pin_oe_n),
  .o_in_reset(o_in_reset), .o_vector(o_vector), .o_vector_valid(o_vector_valid),
  .o_cause(o_cause));
`default_nettype wire
